// file: common/pfrim_pkg.sv
`default_nettype none
package pfrim_pkg;

   // ----------------------------------------------------------------
   // Input mode codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_NONE = 4'h0;
   localparam logic [3:0] MODE_WAIT_REL = 4'h1;
   localparam logic [3:0] MODE_RUN_WAIT = 4'h2;
   localparam logic [3:0] MODE_REPEAT = 4'h3;
   localparam logic [3:0] MODE_DEACT = 4'h4;
   localparam logic [3:0] MODE_INS_DT = 4'h5;
   localparam logic [3:0] MODE_JUMP_WAIT = 4'h6;
   localparam logic [3:0] MODE_HALT = 4'h7;
   localparam logic [3:0] MODE_RETRIG = 4'h8;
   localparam logic [3:0] MODE_FIX_RETRIG = 4'h9;
   localparam logic [3:0] MODE_FIX_DEACT = 4'he;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG_A = 8'h04;
   localparam logic [7:0] ADDR_CFG_B = 8'h08;
   localparam logic [7:0] ADDR_DT0 = 8'h0c;
   localparam logic [7:0] ADDR_OT0 = 8'h10;
   localparam logic [7:0] ADDR_DT1 = 8'h14;
   localparam logic [7:0] ADDR_OT1 = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_ONE_RAMP_BIT = 1;
   localparam int CFG_LEVEL_BIT = 4;
   localparam int CFG_FILTER_BIT = 5;
   localparam logic CTRL_RUN_RST = 1'b0;
   localparam logic CTRL_ONE_RAMP_RST = 1'b0;
   localparam logic [5:0] CFG_RST = 6'h00;
   localparam logic [11:0] TIME_RST = 12'h001;

   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam logic [2:0] FILT_CYCLES = 3'h4;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h0,
      ST_DT0   = 4'h1,
      ST_OT0   = 4'h2,
      ST_DT1   = 4'h3,
      ST_OT1   = 4'h4,
      ST_WAIT0 = 4'h5,
      ST_WAIT1 = 4'h6
   } pfrim_state_t;

endpackage
`default_nettype wire

// file: hw/pfrim_top.sv
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pfrim_top
   import pfrim_pkg::*;
(
   input wire logic clk, // Generator clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, words only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // Always ready
   output logic hresp, // Always OKAY
   output logic [31:0] hrdata, // AHB read data
   input wire logic in_a, // Fault or retrigger input A
   input wire logic in_b, // Fault or retrigger input B
   output logic waveform_output_0, // Output 0, active in on-time 0
   output logic waveform_output_1 // Output 1, active in on-time 1
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   pfrim_state_t st_r, st_nxt;
   logic [11:0] cnt_r, cnt_nxt, len_nxt, cnt_ld;
   logic [11:0] dt0_r, ot0_r, dt1_r, ot1_r;
   logic [5:0] cfg_a_r, cfg_b_r;
   logic run_r, run_nxt, one_ramp_r;
   logic pend_a_r, pend_a_nxt, pend_b_r, pend_b_nxt;
   logic wsrc_r, wsrc_nxt;
   logic kill0_r, kill0_nxt, kill1_r, kill1_nxt;
   logic out0_r, out1_r;
   logic wr_en_r, rd_acc;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r, rd_mux;
   logic [1:0] act, edge_w;
   wire [1:0] raw_in = {in_b, in_a};
   wire [5:0] cfg_w [2];

   assign cfg_w[0] = cfg_a_r;
   assign cfg_w[1] = cfg_b_r;

   // ----------------------------------------------------------------
   // Input conditioning per input
   // ----------------------------------------------------------------
   for (genvar gi = 0; gi < 2; gi++) begin : g_in
      logic s1_r, s2_r, filt_r, act_prev_r;
      logic [2:0] fcnt_r;
      wire filt_en = cfg_w[gi][CFG_FILTER_BIT];
      wire cond = filt_en ? filt_r : s2_r;
      // Polarity: active when conditioned level equals level bit
      assign act[gi] = ~(cond ^ cfg_w[gi][CFG_LEVEL_BIT]);
      assign edge_w[gi] = act[gi] & ~act_prev_r;

      // Two-stage synchroniser, stable-for-four filter
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            filt_r <= 1'b0;
            fcnt_r <= 3'h0;
            act_prev_r <= 1'b1;
         end else begin
            s1_r <= raw_in[gi];
            s2_r <= s1_r;
            act_prev_r <= act[gi];
            if (s2_r == filt_r) begin
               fcnt_r <= 3'h0;
            end else if (fcnt_r == FILT_CYCLES - 3'h1) begin
               filt_r <= s2_r;
               fcnt_r <= 3'h0;
            end else begin
               fcnt_r <= fcnt_r + 3'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   wire [3:0] mode_a = cfg_a_r[3:0];
   wire [3:0] mode_b = cfg_b_r[3:0];
   wire own_a = (st_r == ST_DT0) || (st_r == ST_OT0);
   wire own_b = (st_r == ST_DT1) || (st_r == ST_OT1);
   wire lvl_mode_a = (mode_a == MODE_WAIT_REL) || (mode_a == MODE_RUN_WAIT) ||
                     (mode_a == MODE_REPEAT);
   wire lvl_mode_b = (mode_b == MODE_WAIT_REL) || (mode_b == MODE_RUN_WAIT) ||
                     (mode_b == MODE_REPEAT);
   wire lvl_a = lvl_mode_a && act[0] && own_a && !pend_a_r;
   wire lvl_b = lvl_mode_b && act[1] && own_b && !pend_b_r;
   wire frc = (mode_a == MODE_DEACT && act[0]) ||
              (mode_b == MODE_DEACT && act[1]);
   wire ins_a = mode_a == MODE_INS_DT && act[0];
   wire ins_b = mode_b == MODE_INS_DT && act[1];
   wire jw_a = mode_a == MODE_JUMP_WAIT && act[0];
   wire jw_b = mode_b == MODE_JUMP_WAIT && act[1];
   wire halt_evt = (mode_a == MODE_HALT && act[0]) ||
                   (mode_b == MODE_HALT && act[1]);
   wire rt_a = mode_a == MODE_RETRIG && edge_w[0] && st_r == ST_OT0;
   wire rt_b = mode_b == MODE_RETRIG && edge_w[1] && st_r == ST_OT1;
   wire fx_a = (mode_a == MODE_FIX_RETRIG || mode_a == MODE_FIX_DEACT) &&
               edge_w[0] && st_r == ST_OT0;
   wire fx_b = (mode_b == MODE_FIX_RETRIG || mode_b == MODE_FIX_DEACT) &&
               edge_w[1] && st_r == ST_OT1;
   wire timed = (st_r == ST_DT0) || (st_r == ST_OT0) ||
                (st_r == ST_DT1) || (st_r == ST_OT1);
   wire ph_end = timed && (cnt_r == 12'h000);

   // ----------------------------------------------------------------
   // Register bus decode
   // ----------------------------------------------------------------
   wire acc = hsel && hready && htrans[1];
   assign rd_acc = acc && !hwrite;
   wire wr_ctrl = wr_en_r && wr_addr_r == ADDR_CTRL;
   wire wr_cfg_a = wr_en_r && wr_addr_r == ADDR_CFG_A;
   wire wr_cfg_b = wr_en_r && wr_addr_r == ADDR_CFG_B;
   wire wr_dt0 = wr_en_r && wr_addr_r == ADDR_DT0;
   wire wr_ot0 = wr_en_r && wr_addr_r == ADDR_OT0;
   wire wr_dt1 = wr_en_r && wr_addr_r == ADDR_DT1;
   wire wr_ot1 = wr_en_r && wr_addr_r == ADDR_OT1;
   wire [7:0] ra = haddr[7:0];
   wire hi_zero = haddr[31:8] == 24'h000000;
   assign rd_mux = !hi_zero ? 32'h00000000 :
                   ra == ADDR_CTRL ? {30'h0, one_ramp_r, run_r} :
                   ra == ADDR_CFG_A ? {26'h0, cfg_a_r} :
                   ra == ADDR_CFG_B ? {26'h0, cfg_b_r} :
                   ra == ADDR_DT0 ? {20'h0, dt0_r} :
                   ra == ADDR_OT0 ? {20'h0, ot0_r} :
                   ra == ADDR_DT1 ? {20'h0, dt1_r} :
                   ra == ADDR_OT1 ? {20'h0, ot1_r} :
                   ra == ADDR_STATUS ? {23'h0, run_r, act, out1_r, out0_r, st_r} :
                   32'h00000000;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // Software set of run beats a halt in the same cycle
   assign run_nxt = wr_ctrl ? hwdata[CTRL_RUN_BIT] :
                    halt_evt ? 1'b0 : run_r;

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      pend_a_nxt = pend_a_r;
      pend_b_nxt = pend_b_r;
      wsrc_nxt = wsrc_r;
      if (!run_r || halt_evt) begin
         st_nxt = ST_IDLE;
         pend_a_nxt = 1'b0;
         pend_b_nxt = 1'b0;
      end else if (st_r == ST_IDLE) begin
         st_nxt = ST_DT0;
      end else if (st_r == ST_WAIT0 || st_r == ST_WAIT1) begin
         if (!act[wsrc_r]) begin
            st_nxt = (st_r == ST_WAIT0) ? ST_DT0 : ST_DT1;
         end
      end else if (lvl_a) begin
         if (mode_a == MODE_WAIT_REL) begin
            st_nxt = ST_WAIT1;
            wsrc_nxt = 1'b0;
         end else begin
            st_nxt = ST_DT1;
            pend_a_nxt = 1'b1;
         end
      end else if (lvl_b) begin
         if (mode_b == MODE_WAIT_REL) begin
            st_nxt = ST_WAIT0;
            wsrc_nxt = 1'b1;
         end else begin
            st_nxt = ST_DT0;
            pend_b_nxt = 1'b1;
         end
      end else if (jw_a || jw_b) begin
         st_nxt = own_a ? ST_WAIT1 : ST_WAIT0;
         wsrc_nxt = !jw_a;
      end else if ((ins_a || ins_b) && st_r == ST_OT0) begin
         st_nxt = ST_DT1;
      end else if ((ins_a || ins_b) && st_r == ST_OT1) begin
         st_nxt = ST_DT0;
      end else if (rt_a) begin
         st_nxt = one_ramp_r ? ST_IDLE : ST_DT1;
      end else if (rt_b) begin
         st_nxt = ST_DT0;
      end else if (ph_end) begin
         case (st_r)
            ST_DT0: begin
               if (pend_a_r && mode_a == MODE_REPEAT && act[0]) begin
                  st_nxt = ST_DT1;
               end else begin
                  st_nxt = ST_OT0;
                  pend_a_nxt = 1'b0;
               end
            end
            ST_OT0: begin
               st_nxt = ST_DT1;
               if (pend_b_r && mode_b == MODE_RUN_WAIT) begin
                  pend_b_nxt = 1'b0;
                  if (act[1]) begin
                     st_nxt = ST_WAIT1;
                     wsrc_nxt = 1'b1;
                  end
               end
            end
            ST_DT1: begin
               if (pend_b_r && mode_b == MODE_REPEAT && act[1]) begin
                  st_nxt = ST_DT0;
               end else begin
                  st_nxt = ST_OT1;
                  pend_b_nxt = 1'b0;
               end
            end
            default: begin
               st_nxt = ST_DT0;
               if (pend_a_r && mode_a == MODE_RUN_WAIT) begin
                  pend_a_nxt = 1'b0;
                  if (act[0]) begin
                     st_nxt = ST_WAIT0;
                     wsrc_nxt = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // Phase length on entry; a zero length still lasts one cycle
   assign len_nxt = (st_nxt == ST_DT0) ? dt0_r :
                    (st_nxt == ST_OT0) ? ot0_r :
                    (st_nxt == ST_DT1) ? dt1_r : ot1_r;
   assign cnt_ld = (len_nxt == 12'h000) ? 12'h000 : len_nxt - 12'h001;
   assign cnt_nxt = (st_nxt != st_r) ? cnt_ld :
                    timed ? cnt_r - 12'h001 : cnt_r;

   // Output kill: mode 9 until on-time ends, mode 14 while input active
   assign kill0_nxt = fx_a ? 1'b1 :
                      (mode_a == MODE_FIX_DEACT) ? kill0_r && act[0] :
                      kill0_r && st_nxt == ST_OT0;
   assign kill1_nxt = fx_b ? 1'b1 :
                      (mode_b == MODE_FIX_DEACT) ? kill1_r && act[1] :
                      kill1_r && st_nxt == ST_OT1;

   // ----------------------------------------------------------------
   // Sequencer and output registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= ST_IDLE;
         cnt_r <= 12'h000;
         pend_a_r <= 1'b0;
         pend_b_r <= 1'b0;
         wsrc_r <= 1'b0;
         kill0_r <= 1'b0;
         kill1_r <= 1'b0;
         out0_r <= 1'b0;
         out1_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         pend_a_r <= pend_a_nxt;
         pend_b_r <= pend_b_nxt;
         wsrc_r <= wsrc_nxt;
         kill0_r <= kill0_nxt;
         kill1_r <= kill1_nxt;
         out0_r <= st_nxt == ST_OT0 && !kill0_nxt && !frc;
         out1_r <= st_nxt == ST_OT1 && !kill1_nxt && !frc;
      end
   end
   assign waveform_output_0 = out0_r;
   assign waveform_output_1 = out1_r;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         run_r <= CTRL_RUN_RST;
         one_ramp_r <= CTRL_ONE_RAMP_RST;
         cfg_a_r <= CFG_RST;
         cfg_b_r <= CFG_RST;
         dt0_r <= TIME_RST;
         ot0_r <= TIME_RST;
         dt1_r <= TIME_RST;
         ot1_r <= TIME_RST;
         wr_en_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
      end else begin
         run_r <= run_nxt;
         wr_en_r <= acc && hwrite && hi_zero;
         wr_addr_r <= ra;
         if (rd_acc) hrdata_r <= rd_mux;
         if (wr_ctrl) one_ramp_r <= hwdata[CTRL_ONE_RAMP_BIT];
         if (wr_cfg_a) cfg_a_r <= hwdata[5:0];
         if (wr_cfg_b) cfg_b_r <= hwdata[5:0];
         if (wr_dt0) dt0_r <= hwdata[11:0];
         if (wr_ot0) ot0_r <= hwdata[11:0];
         if (wr_dt1) dt1_r <= hwdata[11:0];
         if (wr_ot1) ot1_r <= hwdata[11:0];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   mode_zero_a: assert property (($past(mode_a) == MODE_NONE && $past(mode_b) == MODE_NONE
      && !kill0_r && !kill1_r) |-> (out0_r == (st_r == ST_OT0)))
      else $error("mode zero changed output 0");
   own_phase_a: assert property ((run_r && run_nxt && mode_a == MODE_WAIT_REL
      && mode_b == MODE_NONE && st_r == ST_OT1 && cnt_r != 12'h000) |=> st_r == ST_OT1)
      else $error("input A acted outside its half");
   enter_wait_a: assert property ((run_r && run_nxt && mode_a == MODE_WAIT_REL
      && st_r == ST_OT0 && act[0] && !pend_a_r) |=> (st_r == ST_WAIT1 && !out0_r))
      else $error("mode 1 did not release output 0");
   wait_release_a: assert property ((st_r == ST_WAIT1 && !wsrc_r && run_nxt && !halt_evt)
      |=> ($past(act[0]) ? st_r == ST_WAIT1 : st_r == ST_DT1))
      else $error("mode 1 wait mishandled");
   jump_opp_a: assert property ((run_r && run_nxt && mode_a == MODE_RUN_WAIT
      && own_a && act[0] && !pend_a_r) |=> (st_r == ST_DT1 && pend_a_r))
      else $error("mode 2 did not jump to dead-time 1");
   finish_sub_a: assert property ((st_r == ST_DT1 && pend_a_r && cnt_r != 12'h000
      && run_nxt && mode_b == MODE_NONE) |=> st_r == ST_DT1)
      else $error("opposite sub-cycle cut short");
   deact_timing_a: assert property (((mode_a == MODE_DEACT && act[0])
      || (mode_b == MODE_DEACT && act[1])) |=> (!out0_r && !out1_r))
      else $error("mode 4 left an output active");
   halt_gen_a: assert property ((run_r && mode_a == MODE_HALT && act[0] && !wr_ctrl)
      |=> (!run_r && st_r == ST_IDLE && !out0_r) ##1 (st_r == ST_IDLE || run_r))
      else $error("mode 7 did not halt");
   retrig_win_a: assert property ((run_nxt && mode_a == MODE_RETRIG && mode_b == MODE_NONE
      && edge_w[0] && st_r == ST_DT0 && cnt_r != 12'h000) |=> st_r == ST_DT0)
      else $error("retrigger accepted outside on-time");
   fix_deact_a: assert property ((run_nxt && (mode_a == MODE_FIX_RETRIG
      || mode_a == MODE_FIX_DEACT) && mode_b == MODE_NONE
      && edge_w[0] && st_r == ST_OT0 && cnt_r != 12'h000)
      |=> (!out0_r && st_r == ST_OT0 && cnt_r == $past(cnt_r) - 12'h001))
      else $error("mode 9 changed timing or kept output");
   filter_len_a: assert property ((cfg_a_r[CFG_FILTER_BIT] && $changed(g_in[0].filt_r))
      |-> ($past(g_in[0].s2_r, 1) == g_in[0].filt_r
      && $past(g_in[0].s2_r, 4) == g_in[0].filt_r))
      else $error("filter passed a short pulse");

   wait_seen_c: cover property (st_r == ST_WAIT1 ##1 st_r == ST_DT1);
   repeat_seen_c: cover property (pend_a_r && st_r == ST_DT0 ##1 st_r == ST_DT1);
   retrig_seen_c: cover property (rt_b);
   halt_seen_c: cover property (run_r && halt_evt ##1 !run_r);

endmodule // pfrim_top
`default_nettype wire

// file: verif/pfrim_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Fault or retrigger source
// ----------------------------------------------------------------
module pfrim_src_model (
   input wire logic want_a, // Input A asserted
   input wire logic want_b, // Input B asserted
   input wire logic level_a, // A asserts high when set
   input wire logic level_b, // B asserts high when set
   output logic in_a, // Line A
   output logic in_b // Line B
);
   // Asserted state mapped onto the chosen line polarity
   assign in_a = level_a ? want_a : ~want_a;
   assign in_b = level_b ? want_b : ~want_b;
endmodule // pfrim_src_model
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pfrim_pkg::*;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, in_a, in_b, out0, out1;
   logic [31:0] hrdata, st;
   logic want_a = 1'b0;
   logic want_b = 1'b0;
   logic level_a = 1'b1;
   logic level_b = 1'b0;
   logic seen;
   int fails = 0;
   int total_checks = 0;
   int i;

   // Clock at 25 MHz
   always #20 clk = ~clk;

   pfrim_top i_pfrim_top (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_a(in_a), .in_b(in_b),
      .waveform_output_0(out0), .waveform_output_1(out1));
   pfrim_src_model i_pfrim_src_model (.want_a(want_a), .want_b(want_b), .level_a(level_a),
      .level_b(level_b), .in_a(in_a), .in_b(in_b));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic results;
      if (fails == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Bounded wait for hready at a rising edge
   task automatic hw;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 16) begin
            fails++;
            results();
         end
         @(posedge clk);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      hw();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      hw();
   endtask

   task automatic rd(input logic [7:0] a);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      hw();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hw();
      st = hrdata;
   endtask

   // Poll the status state field, bounded
   task automatic wait_st(input logic [3:0] s);
      int n;
      for (n = 0; n < 200; n++) begin
         rd(ADDR_STATUS);
         if (st[3:0] === s) return;
      end
      fails++;
      $display("[ERR] state expected %h seen %h", s, st[3:0]);
      results();
   endtask

   function automatic logic [31:0] cfg(input logic lvl, input logic [3:0] m);
      return {26'h0, 1'b0, lvl, m};
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // Reset values and unmapped space
      rd(ADDR_CTRL); chk("ctrl", 32'h0, st);
      rd(ADDR_CFG_A); chk("cfg_a", 32'h0, st);
      rd(ADDR_DT0); chk("dt0", 32'h1, st);
      rd(ADDR_STATUS); chk("status", 32'h40, st);
      chk("hresp", 32'h0, {31'h0, hresp});
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40); chk("unmapped", 32'h0, st);
      wr(ADDR_DT0, 32'h4);
      wr(ADDR_DT1, 32'h4);
      wr(ADDR_OT0, 32'h10);
      wr(ADDR_OT1, 32'h10);
      rd(ADDR_OT1); chk("ot1", 32'h10, st);
      // Mode zero ignores an asserted input
      wr(ADDR_CFG_A, cfg(1'b1, MODE_NONE));
      want_a <= 1'b1;
      wr(ADDR_CTRL, 32'h1);
      wait_st(ST_OT0); chk("m0_out0", 32'h10, st & 32'h10);
      chk("pin0", 32'h1, {31'h0, out0});
      want_a <= 1'b0;
      // Mode 1 holds until release, then opposite half
      wr(ADDR_CFG_A, cfg(1'b1, MODE_WAIT_REL));
      wait_st(ST_OT0);
      want_a <= 1'b1;
      repeat (6) @(posedge clk);
      for (i = 0; i < 12; i++) begin
         rd(ADDR_STATUS);
         chk("m1_out0", 32'h0, st & 32'h10);
         chk("m1_hold", 32'h0, {31'h0, st[3:0] === ST_DT1});
      end
      want_a <= 1'b0;
      wait_st(ST_DT1);
      wait_st(ST_OT1); chk("m1_out1", 32'h20, st & 32'h20);
      chk("pin1", 32'h1, {31'h0, out1});
      // Mode 2 runs the opposite half to completion
      wr(ADDR_CFG_A, cfg(1'b1, MODE_RUN_WAIT));
      wait_st(ST_OT0);
      want_a <= 1'b1;
      wait_st(ST_DT1);
      want_a <= 1'b0;
      wait_st(ST_OT1); chk("m2_out1", 32'h20, st & 32'h20);
      // Mode 4 on B, asserted low
      wr(ADDR_CFG_A, 32'h0);
      wr(ADDR_CFG_B, cfg(1'b0, MODE_DEACT));
      want_b <= 1'b1;
      repeat (6) @(posedge clk);
      seen = 1'b0;
      for (i = 0; i < 16; i++) begin
         rd(ADDR_STATUS);
         chk("m4_off", 32'h0, st & 32'h30);
         if (st[3:0] === ST_OT0 || st[3:0] === ST_OT1) seen = 1'b1;
      end
      chk("m4_timing", 32'h1, {31'h0, seen});
      want_b <= 1'b0;
      wr(ADDR_CFG_B, 32'h0);
      // Mode 9 edge clears output, back next ramp
      level_b <= 1'b1;
      wr(ADDR_CFG_B, cfg(1'b1, MODE_FIX_RETRIG));
      wait_st(ST_DT1);
      wait_st(ST_OT1);
      want_b <= 1'b1;
      repeat (5) @(posedge clk);
      rd(ADDR_STATUS); chk("m9_off", {28'h0, ST_OT1}, st & 32'h2f);
      wait_st(ST_DT0);
      wait_st(ST_OT1); chk("m9_back", 32'h20, st & 32'h20);
      want_b <= 1'b0;
      wr(ADDR_CFG_B, 32'h0);
      // Mode 7 halts until run is set again
      wr(ADDR_CFG_A, cfg(1'b1, MODE_HALT));
      want_a <= 1'b1;
      repeat (8) @(posedge clk);
      rd(ADDR_STATUS); chk("m7_halt", 32'h0, st & 32'h10f);
      want_a <= 1'b0;
      repeat (8) @(posedge clk);
      rd(ADDR_STATUS); chk("m7_stays", 32'h0, st & 32'h10f);
      wr(ADDR_CTRL, 32'h1);
      wait_st(ST_DT0); chk("m7_rerun", 32'h100, st & 32'h100);
      // Mode 8 on B: edge in on-time 1 jumps to dead-time 0
      wr(ADDR_CFG_B, cfg(1'b1, MODE_RETRIG));
      wait_st(ST_DT1);
      wait_st(ST_OT1);
      want_b <= 1'b1;
      repeat (5) @(posedge clk);
      rd(ADDR_STATUS); chk("m8_retrig", {28'h0, ST_DT0}, st & 32'h2f);
      want_b <= 1'b0;
      // Mode 5 on B: on-time cut, dead-time inserted
      wr(ADDR_CFG_B, cfg(1'b1, MODE_INS_DT));
      wait_st(ST_DT1);
      wait_st(ST_OT1);
      want_b <= 1'b1;
      repeat (5) @(posedge clk);
      rd(ADDR_STATUS); chk("m5_insert", {28'h0, ST_DT0}, st & 32'h2f);
      want_b <= 1'b0;
      wr(ADDR_CFG_B, 32'h0);
      // Mode 14 on A: output off while active, ramp kept
      wr(ADDR_CFG_A, cfg(1'b1, MODE_FIX_DEACT));
      wait_st(ST_DT0);
      wait_st(ST_OT0);
      want_a <= 1'b1;
      repeat (5) @(posedge clk);
      rd(ADDR_STATUS); chk("m14_off", {28'h0, ST_OT0}, st & 32'h1f);
      chk("pin0_off", 32'h0, {31'h0, out0});
      wait_st(ST_DT1);
      wait_st(ST_OT0); chk("m14_held", {28'h0, ST_OT0}, st & 32'h1f);
      want_a <= 1'b0;
      wait_st(ST_DT1);
      wait_st(ST_OT0); chk("m14_back", 32'h10, st & 32'h10);
      // Mode 3 on A: opposite half repeats, on-time 0 skipped
      wr(ADDR_CFG_A, cfg(1'b1, MODE_REPEAT));
      wait_st(ST_DT0);
      wait_st(ST_OT0);
      want_a <= 1'b1;
      repeat (4) @(posedge clk);
      for (i = 0; i < 14; i++) begin
         rd(ADDR_STATUS);
         chk("m3_no_ot0", 32'h0, {31'h0, st[3:0] === ST_OT0});
      end
      want_a <= 1'b0;
      wait_st(ST_OT0); chk("m3_back", 32'h10, st & 32'h10);
      // Mode 6 on A: jump to wait, then opposite dead-time
      wr(ADDR_CFG_A, cfg(1'b1, MODE_JUMP_WAIT));
      wait_st(ST_DT0);
      wait_st(ST_OT0);
      want_a <= 1'b1;
      repeat (5) @(posedge clk);
      rd(ADDR_STATUS); chk("m6_wait", {28'h0, ST_WAIT1}, st & 32'h1f);
      want_a <= 1'b0;
      wait_st(ST_DT1);
      // Mode 8 on A in single-ramp restarts the ramp
      wr(ADDR_CTRL, 32'h3);
      wr(ADDR_CFG_A, cfg(1'b1, MODE_RETRIG));
      wait_st(ST_DT0);
      wait_st(ST_OT0);
      want_a <= 1'b1;
      repeat (5) @(posedge clk);
      rd(ADDR_STATUS); chk("m8_restart", {28'h0, ST_DT0}, st & 32'h1f);
      want_a <= 1'b0;
      // Filter holds a new level back for four cycles
      repeat (8) @(posedge clk);
      wr(ADDR_CFG_A, cfg(1'b1, MODE_DEACT) | 32'h20);
      want_a <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADDR_STATUS); chk("filt_hold", 32'h0, st & 32'h40);
      repeat (4) @(posedge clk);
      rd(ADDR_STATUS); chk("filt_pass", 32'h40, st & 32'h70);
      want_a <= 1'b0;
      results();
   end
endmodule // testbench
`default_nettype wire
